//--- hw/ess_block.sv
// Purpose: Embedded synchronous SRAM block, dual-port and two-port variants
// Assumes: Each port edge is a one-cycle clock_en strobe on pclk from fabric logic
// Notes:   Configuration lives in the APB control register
`timescale 1ns/100ps
module ess_block
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire ess_pkg::ess_dp_req_t port_a_request,
	input  wire ess_pkg::ess_dp_req_t port_b_request,
	output logic [8:0]                port_a_read_data,
	output logic [8:0]                port_b_read_data,
	input  wire ess_pkg::ess_tp_wr_t  two_port_write_request,
	input  wire ess_pkg::ess_tp_rd_t  two_port_read_request,
	output logic [17:0]               two_port_read_data
);
	import ess_pkg::*;

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	logic [8:0]               mem [ESS_WORDS];
	logic [ESS_CTRL_BITS-1:0] ctrl_r, ctrl_nxt;
	logic [3:0]               init_bit_r, init_bit_nxt;
	logic [9:0]               init_word_r, init_word_nxt;
	logic [7:0]               init_acc_r, init_acc_nxt;
	logic [31:0]              prdata_r, prdata_nxt;
	logic                     pslverr_r, pslverr_nxt;
	logic [8:0]               out1_r [2], out1_nxt [2];
	logic [8:0]               out2_r [2], out2_nxt [2];
	logic [17:0]              tp1_r, tp1_nxt;
	logic [17:0]              tp2_r, tp2_nxt;

	ess_dp_req_t              dp [2];
	ess_width_t               w_dp [2];
	ess_width_t               w_tw, w_tr;
	logic [1:0]               dp_pipe, dp_policy, dp_rd, dp_wr;
	logic [17:0]              dp_val [2], tp_val;
	logic                     two_port, tp_pipe, tp_we, tp_re;
	logic                     init_shift, init_done;
	logic                     apb_wr, apb_setup, mapped;
	ess_slot_t                slot [3];
	ess_tp_wr_t               tpw;
	ess_tp_rd_t               tpr;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic ess_width_t dp_width(input logic [1:0] code);
		unique case (code)
			ESS_DP_4KX1:  dp_width = ESS_W1;
			ESS_DP_2KX2:  dp_width = ESS_W2;
			ESS_DP_1KX4:  dp_width = ESS_W4;
			ESS_DP_512X9: dp_width = ESS_W9;
		endcase
	endfunction

	function automatic ess_width_t tp_width(input logic [1:0] code);
		unique case (code)
			ESS_TP_512X9:  tp_width = ESS_W9;
			ESS_TP_256X18: tp_width = ESS_W18;
			default:       tp_width = ESS_WNONE;
		endcase
	endfunction

	// Lowest address lands in the lowest bits of a word
	function automatic logic [3:0] bit_pos(input ess_width_t w, input logic [11:0] a);
		unique case (w)
			ESS_W1:  bit_pos = {1'b0, a[2:0]};
			ESS_W2:  bit_pos = {1'b0, a[1:0], 1'b0};
			ESS_W4:  bit_pos = {1'b0, a[0], 2'h0};
			default: bit_pos = 4'h0;
		endcase
	endfunction

	// High address bits ignored; fabric keeps them low
	function automatic logic [8:0] word_of(input ess_width_t w, input logic [11:0] a,
		input logic hi);
		unique case (w)
			ESS_W1:  word_of = a[11:3];
			ESS_W2:  word_of = a[10:2];
			ESS_W4:  word_of = a[9:1];
			ESS_W18: word_of = {a[7:0], hi};
			default: word_of = a[8:0];
		endcase
	endfunction

	function automatic ess_slot_t wr_slot(input logic en, input ess_width_t w,
		input logic [11:0] a, input logic [17:0] d, input logic hi);
		logic [8:0] lane;
		ess_slot_t  s;
		unique case (w)
			ESS_W1:  lane = 9'h001;
			ESS_W2:  lane = 9'h003;
			ESS_W4:  lane = 9'h00F;
			default: lane = 9'h1FF;
		endcase
		s.en   = en;
		s.word = word_of(w, a, hi);
		s.mask = lane << bit_pos(w, a);
		s.data = (hi ? d[17:9] : d[8:0]) << bit_pos(w, a);
		wr_slot = s;
	endfunction

	// Unused output bits read as zero
	function automatic logic [17:0] rd_value(input ess_width_t w, input logic [11:0] a,
		input logic [8:0] lo, input logic [8:0] hi);
		logic [8:0] sh;
		sh = lo >> bit_pos(w, a);
		unique case (w)
			ESS_W1:  rd_value = {17'h00000, sh[0]};
			ESS_W2:  rd_value = {16'h0000, sh[1:0]};
			ESS_W4:  rd_value = {14'h0000, sh[3:0]};
			ESS_W18: rd_value = {hi, lo};
			default: rd_value = {9'h000, lo};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Configuration decode
	// ----------------------------------------------------------------
	// Settings are sampled live; fabric must not change them mid-traffic
	assign two_port     = ctrl_r[ESS_F_TWO_PORT];
	assign dp[0]        = port_a_request;
	assign dp[1]        = port_b_request;
	assign tpw          = two_port_write_request;
	assign tpr          = two_port_read_request;
	assign w_dp[0]      = dp_width(ctrl_r[ESS_F_PORT_A_ASPECT +: 2]);
	assign w_dp[1]      = dp_width(ctrl_r[ESS_F_PORT_B_ASPECT +: 2]);
	assign w_tw         = tp_width(ctrl_r[ESS_F_WRITE_WIDTH_SELECT +: 2]);
	assign w_tr         = tp_width(ctrl_r[ESS_F_READ_WIDTH_SELECT +: 2]);
	assign dp_pipe[0]   = ctrl_r[ESS_F_PORT_A_REGISTERED_OUTPUT];
	assign dp_pipe[1]   = ctrl_r[ESS_F_PORT_B_REGISTERED_OUTPUT];
	assign dp_policy[0] = ctrl_r[ESS_F_PORT_A_WRITE_OUTPUT_POLICY];
	assign dp_policy[1] = ctrl_r[ESS_F_PORT_B_WRITE_OUTPUT_POLICY];
	assign tp_pipe      = ctrl_r[ESS_F_TWO_PORT_REGISTERED_OUTPUT];

	// Enable is asserted when the pin equals the configured active level
	assign tp_we = two_port && tpw.clock_en && w_tw != ESS_WNONE
		&& (tpw.enable == ctrl_r[ESS_F_WRITE_ENABLE_HIGH]);
	assign tp_re = two_port && tpr.clock_en && w_tr != ESS_WNONE
		&& (tpr.enable == ctrl_r[ESS_F_READ_ENABLE_HIGH]);

	// ----------------------------------------------------------------
	// Array access
	// ----------------------------------------------------------------
	// Each port strobe marks its own edge, so ports run at independent rates
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			dp_rd[i] = !two_port && dp[i].clock_en && !dp[i].select_n && dp[i].write_n;
			dp_wr[i] = !two_port && dp[i].clock_en && !dp[i].select_n && !dp[i].write_n;
			dp_val[i] = rd_value(w_dp[i], dp[i].address,
				mem[word_of(w_dp[i], dp[i].address, 1'b0)], 9'h000);
		end
		tp_val = rd_value(w_tr, {3'h0, tpr.address},
			mem[word_of(w_tr, {3'h0, tpr.address}, 1'b0)],
			mem[word_of(w_tr, {3'h0, tpr.address}, 1'b1)]);
	end

	// Later slot wins on a same-bit collision; init load has the last word
	always_comb
	begin
		if (two_port)
		begin
			slot[0] = wr_slot(tp_we, w_tw, {3'h0, tpw.address}, tpw.data, 1'b0);
			slot[1] = wr_slot(tp_we && w_tw == ESS_W18, w_tw, {3'h0, tpw.address},
				tpw.data, 1'b1);
		end
		else
		begin
			slot[0] = wr_slot(dp_wr[0], w_dp[0], dp[0].address,
				{9'h000, dp[0].write_data}, 1'b0);
			slot[1] = wr_slot(dp_wr[1], w_dp[1], dp[1].address,
				{9'h000, dp[1].write_data}, 1'b0);
		end
		slot[2].en   = init_shift && init_bit_r == ESS_INIT_LAST_BIT;
		slot[2].word = init_word_r[8:0];
		slot[2].mask = 9'h1FF;
		slot[2].data = {pwdata[0], init_acc_r};
	end

	// Rising edge only; no reset so contents survive presetn
	always_ff @(posedge pclk)
	begin
		for (int s = 0; s < 3; s++)
		begin
			for (int b = 0; b < 9; b++)
			begin
				if (presetn && slot[s].en && slot[s].mask[b])
					mem[slot[s].word][b] <= slot[s].data[b];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output pipelines
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			out1_nxt[i] = out1_r[i];
			out2_nxt[i] = out2_r[i];
			if (dp_rd[i])
				out1_nxt[i] = dp_val[i][8:0];
			else if (dp_wr[i] && dp_policy[i])
				out1_nxt[i] = dp[i].write_data;
			if (!two_port && dp[i].clock_en)
				out2_nxt[i] = out1_r[i];
		end
		tp1_nxt = tp_re ? tp_val : tp1_r;
		tp2_nxt = (two_port && tpr.clock_en) ? tp1_r : tp2_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out1_r <= '{default: 9'h000};
			out2_r <= '{default: 9'h000};
			tp1_r  <= 18'h00000;
			tp2_r  <= 18'h00000;
		end
		else
		begin
			out1_r <= out1_nxt;
			out2_r <= out2_nxt;
			tp1_r  <= tp1_nxt;
			tp2_r  <= tp2_nxt;
		end
	end

	assign port_a_read_data   = dp_pipe[0] ? out2_r[0] : out1_r[0];
	assign port_b_read_data   = dp_pipe[1] ? out2_r[1] : out1_r[1];
	assign two_port_read_data = tp_pipe ? tp2_r : tp1_r;

	// ----------------------------------------------------------------
	// Serial initialisation
	// ----------------------------------------------------------------
	// One bit per APB write, least significant bit of each word first
	assign init_done  = init_word_r == ESS_INIT_WORDS;
	assign init_shift = apb_wr && paddr == ESS_INIT_SHIFT_OFF && !init_done;

	always_comb
	begin
		init_bit_nxt  = init_bit_r;
		init_word_nxt = init_word_r;
		init_acc_nxt  = init_acc_r;
		if (apb_wr && paddr == ESS_INIT_CTRL_OFF && pwdata[0])
		begin
			init_bit_nxt  = 4'h0;
			init_word_nxt = 10'h000;
		end
		else if (init_shift)
		begin
			if (init_bit_r == ESS_INIT_LAST_BIT)
			begin
				init_bit_nxt  = 4'h0;
				init_word_nxt = init_word_r + 10'h001;
			end
			else
			begin
				init_bit_nxt = init_bit_r + 4'h1;
				init_acc_nxt = {pwdata[0], init_acc_r[7:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------------------------------
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign mapped    = paddr == ESS_CTRL_OFF || paddr == ESS_STATUS_OFF
		|| paddr == ESS_INIT_CTRL_OFF || paddr == ESS_INIT_SHIFT_OFF;

	always_comb
	begin
		ctrl_nxt    = ctrl_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = pslverr_r;
		if (apb_wr && paddr == ESS_CTRL_OFF)
			ctrl_nxt = pwdata[ESS_CTRL_BITS-1:0];
		if (apb_setup)
		begin
			pslverr_nxt = !mapped;
			prdata_nxt  = 32'h0000_0000;
			if (paddr == ESS_CTRL_OFF)
				prdata_nxt = {16'h0000, ctrl_r};
			else if (paddr == ESS_STATUS_OFF)
			begin
				prdata_nxt[ESS_F_INIT_WORDS +: 10]   = init_word_r;
				prdata_nxt[ESS_F_INIT_DONE]          = init_done;
				prdata_nxt[ESS_F_WRITE_WIDTH_BAD]    = w_tw == ESS_WNONE;
				prdata_nxt[ESS_F_READ_WIDTH_BAD]     = w_tr == ESS_WNONE;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r      <= ESS_CTRL_RESET;
			prdata_r    <= 32'h0000_0000;
			pslverr_r   <= 1'b0;
			init_bit_r  <= 4'h0;
			init_word_r <= 10'h000;
			init_acc_r  <= 8'h00;
		end
		else
		begin
			ctrl_r      <= ctrl_nxt;
			prdata_r    <= prdata_nxt;
			pslverr_r   <= pslverr_nxt;
			init_bit_r  <= init_bit_nxt;
			init_word_r <= init_word_nxt;
			init_acc_r  <= init_acc_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = pslverr_r && psel && penable;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking ast_clk @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Idle cycle between strobes moves neither output stage
	sequence s_a_read_pipe;
		dp_rd[0] && dp_pipe[0] ##1 !port_a_request.clock_en
			##1 port_a_request.clock_en && dp_pipe[0];
	endsequence

	sequence s_tp_read_pipe;
		tp_re && tp_pipe ##1 !two_port_read_request.clock_en
			##1 two_port_read_request.clock_en && tp_pipe;
	endsequence

	AST_RESET_CLEAR: assert property (
		$rose(presetn) |-> port_a_read_data == 9'h000 && port_b_read_data == 9'h000
			&& two_port_read_data == 18'h00000)
		else $error("outputs not zero after reset");

	AST_FLOW_READ: assert property (
		dp_rd[0] && !dp_pipe[0] ##0 !dp_pipe[0] |=> port_a_read_data == $past(dp_val[0][8:0]))
		else $error("flow-through read data wrong");

	AST_PIPE_READ: assert property (
		s_a_read_pipe |=> port_a_read_data == $past(dp_val[0][8:0], 3))
		else $error("pipelined read data wrong");

	AST_DESELECT_HOLD: assert property (
		!two_port && port_b_request.clock_en && port_b_request.select_n && !dp_pipe[1]
			|=> $stable(port_b_read_data))
		else $error("deselected port output moved");

	AST_WRITE_PASS: assert property (
		dp_wr[1] && dp_policy[1] && !dp_pipe[1]
			|=> port_b_read_data == $past(port_b_request.write_data))
		else $error("pass-through write data missing");

	AST_WRITE_RETAIN: assert property (
		dp_wr[0] && !dp_policy[0] && !dp_pipe[0] |=> $stable(port_a_read_data))
		else $error("retained output changed on write");

	AST_WRITE_STORE: assert property (
		dp_wr[0] && w_dp[0] == ESS_W9 && !dp_wr[1] && !slot[2].en
			|=> mem[$past(port_a_request.address[8:0])] == $past(port_a_request.write_data))
		else $error("9-bit write not stored");

	AST_TP_RESERVED: assert property (
		two_port && two_port_read_request.clock_en && w_tr == ESS_WNONE && !tp_pipe
			|=> $stable(two_port_read_data))
		else $error("reserved width read changed output");

	AST_TP_PIPE_READ: assert property (
		s_tp_read_pipe |=> two_port_read_data == $past(tp_val, 3))
		else $error("two-port pipelined read wrong");

	AST_TP_POLARITY: assert property (
		two_port && two_port_write_request.clock_en
			&& two_port_write_request.enable != ctrl_r[ESS_F_WRITE_ENABLE_HIGH]
			|-> !slot[0].en && !slot[1].en)
		else $error("write taken with enable deasserted");

	AST_INIT_LOAD: assert property (
		slot[2].en |=> mem[$past(slot[2].word)] == $past(slot[2].data)
			&& init_bit_r == 4'h0)
		else $error("serial init word not stored");

endmodule // ess_block

//--- shared/ess_pkg.sv
// Purpose: Constants and carrier types shared by the embedded sync SRAM block
// Assumes: APB register access on pclk; port strobes come from fabric logic on pclk
// Notes:   One 512 x 9 bit array backs both the dual-port and the two-port variant
package ess_pkg;

	// ----------------------------------------------------------------
	// Rates and array geometry
	// ----------------------------------------------------------------
	localparam int ESS_PCLK_MHZ        = 20;
	localparam int ESS_PORT_MAX_MHZ    = 350;
	localparam int ESS_WORDS           = 512;
	localparam int ESS_ARRAY_BITS      = 4608;
	localparam logic [9:0] ESS_INIT_WORDS = 10'h200;
	localparam logic [3:0] ESS_INIT_LAST_BIT = 4'h8;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ESS_CTRL_OFF       = 12'h000;
	localparam logic [11:0] ESS_STATUS_OFF     = 12'h004;
	localparam logic [11:0] ESS_INIT_CTRL_OFF  = 12'h008;
	localparam logic [11:0] ESS_INIT_SHIFT_OFF = 12'h00C;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int ESS_CTRL_BITS                    = 16;
	localparam logic [15:0] ESS_CTRL_RESET          = 16'h0000;
	localparam int ESS_F_TWO_PORT                   = 0;
	localparam int ESS_F_PORT_A_ASPECT              = 1;
	localparam int ESS_F_PORT_B_ASPECT              = 3;
	localparam int ESS_F_PORT_A_REGISTERED_OUTPUT   = 5;
	localparam int ESS_F_PORT_B_REGISTERED_OUTPUT   = 6;
	localparam int ESS_F_PORT_A_WRITE_OUTPUT_POLICY = 7;
	localparam int ESS_F_PORT_B_WRITE_OUTPUT_POLICY = 8;
	localparam int ESS_F_WRITE_WIDTH_SELECT         = 9;
	localparam int ESS_F_READ_WIDTH_SELECT          = 11;
	localparam int ESS_F_TWO_PORT_REGISTERED_OUTPUT = 13;
	localparam int ESS_F_WRITE_ENABLE_HIGH          = 14;
	localparam int ESS_F_READ_ENABLE_HIGH           = 15;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int ESS_F_INIT_WORDS      = 0;
	localparam int ESS_F_INIT_DONE       = 10;
	localparam int ESS_F_WRITE_WIDTH_BAD = 11;
	localparam int ESS_F_READ_WIDTH_BAD  = 12;

	// ----------------------------------------------------------------
	// Aspect codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ESS_DP_4KX1   = 2'h0;
	localparam logic [1:0] ESS_DP_2KX2   = 2'h1;
	localparam logic [1:0] ESS_DP_1KX4   = 2'h2;
	localparam logic [1:0] ESS_DP_512X9  = 2'h3;
	localparam logic [1:0] ESS_TP_512X9  = 2'h1;
	localparam logic [1:0] ESS_TP_256X18 = 2'h2;

	typedef enum logic [2:0] {
		ESS_W1    = 3'h0,
		ESS_W2    = 3'h1,
		ESS_W4    = 3'h2,
		ESS_W9    = 3'h3,
		ESS_W18   = 3'h4,
		ESS_WNONE = 3'h7
	} ess_width_t;

	typedef struct packed {
		logic        clock_en;
		logic        select_n;
		logic        write_n;
		logic [11:0] address;
		logic [8:0]  write_data;
	} ess_dp_req_t;

	typedef struct packed {
		logic        clock_en;
		logic        enable;
		logic [8:0]  address;
		logic [17:0] data;
	} ess_tp_wr_t;

	typedef struct packed {
		logic        clock_en;
		logic        enable;
		logic [8:0]  address;
	} ess_tp_rd_t;

	typedef struct packed {
		logic        en;
		logic [8:0]  word;
		logic [8:0]  mask;
		logic [8:0]  data;
	} ess_slot_t;

endpackage

//--- bench/ess_fabric_port.sv
// Purpose: Fabric logic model driving one dual-port port
// Assumes: Bench raises go for one cycle per access
// Notes:   Idle address and data lines show inverted values, never a stale copy
`timescale 1ns/100ps
module ess_fabric_port
(
	input  wire logic            go,
	input  wire logic            sel_n,
	input  wire logic            wr_n,
	input  wire logic [1:0]      aspect,
	input  wire logic [11:0]     idx,
	input  wire logic [8:0]      data,
	output ess_pkg::ess_dp_req_t req
);
	import ess_pkg::*;
	logic [11:0] amask;
	logic [8:0]  dmask;
	// Aspect only moves between accesses while idle
	always_comb
	begin
		amask = 12'hFFF >> aspect;
		dmask = (aspect == 2'h3) ? 9'h1FF : (9'h001 << (1 << aspect)) - 9'h001;
		req.clock_en   = go;
		req.select_n   = sel_n;
		req.write_n    = wr_n;
		req.address    = go ? (idx & amask) : ~idx;
		req.write_data = go ? (data & dmask) : ~data;
	end
endmodule // ess_fabric_port

//--- bench/tb.sv
// Purpose: Self-checking bench for the embedded sync SRAM block
// Assumes: Port edges are one-cycle strobes on pclk
// Notes:   Expectations queue up; a watcher compares them
`timescale 1ns/100ps
module tb;
	import ess_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, cap_err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, cap_rd, ctrl = 32'h0;
	logic [1:0]  go = 2'h0, sel = 2'h3, wrn = 2'h3;
	logic [1:0]  asp [2];
	logic [11:0] idx [2] = '{12'h000, 12'h000};
	logic [8:0]  dat [2] = '{9'h000, 9'h000};
	logic [8:0]  dout [2];
	logic [17:0] tp_out;
	ess_dp_req_t req [2];
	ess_tp_wr_t  twr = '0;
	ess_tp_rd_t  trd = '0;
	int          fails = 0, num_checks = 0, cyc = 0, kinds [$];
	logic [31:0] exps [$];
	event        seen;
	always #25 pclk = ~pclk;
	assign asp[0] = ctrl[2:1];
	assign asp[1] = ctrl[4:3];
	for (genvar g = 0; g < 2; g++)
	begin : g_port
		ess_fabric_port fab (.go(go[g]), .sel_n(sel[g]), .wr_n(wrn[g]), .aspect(asp[g]),
			.idx(idx[g]), .data(dat[g]), .req(req[g]));
	end
	ess_block uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_a_request(req[0]), .port_b_request(req[1]),
		.port_a_read_data(dout[0]), .port_b_read_data(dout[1]),
		.two_port_write_request(twr), .two_port_read_request(trd), .two_port_read_data(tp_out));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task note(input int k, input logic [31:0] e);
		kinds.push_back(k);
		exps.push_back(e);
		-> seen;
	endtask
	task compare(input int k, input logic [31:0] e);
		logic [31:0] got;
		got = (k == 0) ? cap_rd : (k == 1) ? {31'h0, cap_err} :
			(k == 4) ? {14'h0, tp_out} : {23'h0, dout[k - 2]};
		num_checks++;
		if (got !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t kind %0d got %h exp %h", $time, k, got, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		cap_rd = prdata;
		cap_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task setc(input logic [31:0] v);
		apb(1'b1, ESS_CTRL_OFF, v);
		ctrl <= v;
	endtask
	task dp(input int p, input logic sn, input logic wn, input logic [11:0] i, input logic [8:0] d);
		@(posedge pclk);
		go[p] <= 1'b1;
		sel[p] <= sn;
		wrn[p] <= wn;
		idx[p] <= i;
		dat[p] <= d;
		@(posedge pclk);
		go[p] <= 1'b0;
		@(negedge pclk);
	endtask
	task tp(input logic w, input logic en, input logic [8:0] a, input logic [17:0] d);
		@(posedge pclk);
		if (w)
			twr <= '{1'b1, en, a, d};
		else
			trd <= '{1'b1, en, a};
		@(posedge pclk);
		twr.clock_en <= 1'b0;
		trd.clock_en <= 1'b0;
		@(negedge pclk);
	endtask
	// ----------------------------------------------------------------
	// Watcher and timeout
	// ----------------------------------------------------------------
	always @(seen)
	begin
		while (kinds.size() > 0)
			compare(kinds.pop_front(), exps.pop_front());
	end
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fails++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		int          sub;
		logic [31:0] v;
		logic [11:0] ad;
		void'($urandom(63));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ESS_CTRL_OFF, 32'h0);
		note(0, {16'h0, ESS_CTRL_RESET});
		apb(1'b0, 12'h010, 32'h0);
		note(1, 32'h1);
		setc(32'h1E);
		dp(0, 1'b0, 1'b0, 12'h005, 9'h1A5);
		dp(1, 1'b0, 1'b1, 12'h005, 9'h000);
		note(3, 32'h1A5);
		dp(1, 1'b0, 1'b0, 12'h006, 9'h033);
		note(3, 32'h1A5);
		dp(1, 1'b1, 1'b1, 12'h006, 9'h000);
		note(3, 32'h1A5);
		dp(1, 1'b0, 1'b1, 12'h006, 9'h000);
		note(3, 32'h033);
		setc(32'h11E);
		dp(1, 1'b0, 1'b0, 12'h007, 9'h0F0);
		note(3, 32'h0F0);
		$display("test dual port done");
		for (int s = 0; s < 3; s++)
		begin
			sub = $urandom % (8 >> s);
			v = $urandom & ((1 << (1 << s)) - 1);
			ad = (12'h009 << (3 - s)) | sub[11:0];
			setc(32'h118 | (s << 1));
			dp(1, 1'b0, 1'b0, 12'h009, 9'h000);
			dp(0, 1'b0, 1'b0, ad, v[8:0]);
			dp(1, 1'b0, 1'b1, 12'h009, 9'h000);
			note(3, v << (sub << s));
			dp(0, 1'b0, 1'b1, ad, 9'h000);
			note(2, v);
		end
		$display("test aspects done");
		setc(32'h3E);
		dp(0, 1'b0, 1'b1, 12'h005, 9'h000);
		dp(0, 1'b0, 1'b1, 12'h007, 9'h000);
		note(2, 32'h1A5);
		@(posedge pclk);
		presetn <= 1'b0;
		dp(0, 1'b0, 1'b0, 12'h005, 9'h000);
		note(2, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		setc(32'h1E);
		dp(1, 1'b0, 1'b1, 12'h005, 9'h000);
		note(3, 32'h1A5);
		$display("test reset done");
		setc(32'hC01);
		tp(1'b1, 1'b0, 9'h003, 18'h2ABCD);
		tp(1'b0, 1'b0, 9'h006, 18'h0);
		note(4, 32'h1CD);
		tp(1'b0, 1'b0, 9'h007, 18'h0);
		note(4, 32'h155);
		tp(1'b1, 1'b1, 9'h003, 18'h00011);
		tp(1'b0, 1'b0, 9'h006, 18'h0);
		note(4, 32'h1CD);
		setc(32'hCC01);
		tp(1'b1, 1'b1, 9'h003, 18'h00011);
		tp(1'b0, 1'b1, 9'h006, 18'h0);
		note(4, 32'h011);
		setc(32'hC801);
		tp(1'b1, 1'b1, 9'h003, 18'h3FFFF);
		tp(1'b0, 1'b1, 9'h006, 18'h0);
		note(4, 32'h011);
		setc(32'hC401);
		tp(1'b0, 1'b1, 9'h007, 18'h0);
		note(4, 32'h011);
		apb(1'b0, ESS_STATUS_OFF, 32'h0);
		note(0, 32'h1000);
		tp(1'b1, 1'b1, 9'h003, 18'h2ABCD);
		setc(32'hEC01);
		tp(1'b0, 1'b1, 9'h006, 18'h0);
		tp(1'b0, 1'b1, 9'h007, 18'h0);
		note(4, 32'h1CD);
		$display("test two port done");
		setc(32'hC01);
		apb(1'b1, ESS_INIT_CTRL_OFF, 32'h1);
		for (int k = 0; k < ESS_ARRAY_BITS; k++)
			apb(1'b1, ESS_INIT_SHIFT_OFF, ((k / 9) >> (k % 9)) & 1);
		apb(1'b0, ESS_STATUS_OFF, 32'h0);
		note(0, 32'h600);
		setc(32'h1E);
		dp(1, 1'b0, 1'b1, 12'h12C, 9'h000);
		note(3, 32'h12C);
		$display("test init done");
		repeat (2) @(posedge pclk);
		give_verdict();
	end
endmodule // tb
